// *** verilog/thg_gate.sv ***
// Health tests and output gating for a physical random bit source
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Detect dead source from the very first sample
// RULE2: After total failure, never deliver any word
// RULE3: Discard words built from bits after failure
// RULE4: Online test at start-up and throughout operation
// RULE5: No output before start-up pass, none after defect
// RULE6: Online test restarts every window, never on request
// RULE7: Output words are 32 bits wide
// RULE8: Entropy per bit above 0.997 on average
// RULE9: Valid with each word, sticky failure status
module thg_gate (
	input  wire logic                  CLK,
	input  wire logic                  SRST,
	input  wire logic                  RAW_BIT,
	output logic [thg_pkg::WORD_W-1:0] RND_DATA,
	output logic                       RND_VALID,
	input  wire logic                  RND_READY,
	output logic                       STARTUP_OK,
	output logic                       TOTAL_FAIL,
	output logic                       ONLINE_FAIL,
	output logic                       HEALTH_FAIL
);
	import thg_pkg::*;

	// Whole state of the gate in one record
	typedef struct packed {
		logic              sync1;
		logic              sync2;
		logic [DIV_W-1:0]  div;
		logic              run_bit;
		logic [RUN_W-1:0]  run_len;
		logic              tot_fail;
		logic [WIN_W-1:0]  win;
		logic [ONES_W-1:0] ones;
		logic              onl_fail;
		thg_mode_t         mode;
		logic [WORD_W-1:0] word;
		logic [WCNT_W-1:0] wcnt;
		logic              wfull;
	} thg_st_t;

	thg_st_t           st_q;
	thg_st_t           st_d;
	logic              samp;
	logic              rbit;
	logic              win_end;
	logic [ONES_W-1:0] ones_nx;
	logic              win_bad;
	logic              fifo_in_valid;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic              fifo_flush;
	logic              running;

	// Sample strobe from the divider and the settled raw bit
	assign samp    = (st_q.div == DIV_LAST);
	assign rbit    = st_q.sync2;
	assign win_end = samp && (st_q.win == WIN_LAST);
	assign ones_nx = st_q.ones + ONES_W'(rbit);
	assign win_bad = (ones_nx < ONES_LO) || (ones_nx > ONES_HI); // RULE8
	assign running = (st_q.mode == THG_RUN);

	// Words only enter the buffer while the source is trusted
	assign fifo_in_valid  = st_q.wfull && running; // RULE5
	assign fifo_flush     = !running; // RULE3
	assign fifo_out_ready = RND_READY && running;

	// Next-state logic: sampling, both health tests and word assembly
	always_comb
	begin
		st_d       = st_q;
		// Two flops before anything looks at the source
		st_d.sync1 = RAW_BIT;
		st_d.sync2 = st_q.sync1;
		st_d.div   = samp ? DIV_ZERO : st_q.div + DIV_W'(1);

		// A finished word leaves the assembler once the buffer takes it
		if (fifo_in_valid && fifo_in_ready)
		begin
			st_d.wfull = 1'b0;
			st_d.wcnt  = WCNT_ZERO;
		end

		if (samp)
		begin
			// Run length of identical samples; checked from the first sample on
			if (rbit == st_q.run_bit)
			begin
				if (st_q.run_len != RUN_LIMIT)
					st_d.run_len = st_q.run_len + RUN_ONE;
				if (st_q.run_len == RUN_LIMIT - RUN_ONE)
					st_d.tot_fail = 1'b1; // RULE1
			end
			else
			begin
				st_d.run_bit = rbit;
				st_d.run_len = RUN_ONE;
			end

			// Ones count over each window; a new window starts right away
			if (win_end)
			begin
				st_d.win  = WIN_ZERO; // RULE6
				st_d.ones = ONES_ZERO;
				if (win_bad)
					st_d.onl_fail = 1'b1; // RULE4
				else if (st_q.mode == THG_STARTUP && !st_q.tot_fail)
					st_d.mode = THG_RUN; // RULE5
			end
			else
			begin
				st_d.win  = st_q.win + WIN_W'(1);
				st_d.ones = ones_nx;
			end

			// Shift in a bit only while running and the word slot is free
			if (running && !st_q.wfull)
			begin
				st_d.word = {st_q.word[WORD_W-2:0], rbit}; // RULE7
				st_d.wcnt = st_q.wcnt + WCNT_W'(1);
				if (st_q.wcnt == WCNT_LAST)
					st_d.wfull = 1'b1;
			end
		end

		// Any failure freezes the gate for good and drops the part word.
		// The tests lag the real fault, so nothing in flight is trusted.
		if (st_d.tot_fail || st_d.onl_fail)
		begin
			st_d.mode  = THG_FAIL; // RULE2
			st_d.wfull = 1'b0; // RULE3
			st_d.wcnt  = WCNT_ZERO;
		end
	end

	// State register; a sticky failure clears only with reset
	always_ff @(posedge CLK)
	begin
		if (SRST)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Output buffer; back-pressure stalls the word assembler
	thg_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.srst      (SRST),
		.flush     (fifo_flush),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (st_q.word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (RND_DATA)
	);

	// Outputs to the consumer; valid is gated again by the live status
	assign RND_VALID   = fifo_out_valid && running && !st_q.tot_fail
		&& !st_q.onl_fail; // RULE9
	assign STARTUP_OK  = running;
	assign TOTAL_FAIL  = st_q.tot_fail;
	assign ONLINE_FAIL = st_q.onl_fail;
	assign HEALTH_FAIL = st_q.tot_fail || st_q.onl_fail; // RULE9

	// Helper for checks: cycles since the last online test verdict
	logic [GAP_W-1:0] gap_q;

	always_ff @(posedge CLK)
	begin
		if (SRST)
			gap_q <= '0;
		else if (win_end)
			gap_q <= '0;
		else if (gap_q != GAP_MAX)
			gap_q <= gap_q + GAP_W'(1);
	end

	// A run reaching the limit on a sample
	sequence s_run_limit;
		samp && (rbit == st_q.run_bit) && (st_q.run_len == RUN_LIMIT - RUN_ONE);
	endsequence

	property p_total_detect;
		@(posedge CLK) disable iff (SRST)
		s_run_limit |=> TOTAL_FAIL && HEALTH_FAIL && !STARTUP_OK;
	endproperty
	a_total_detect: assert property (p_total_detect) // RULE1
		else $error("dead source run not flagged");

	property p_total_silent;
		@(posedge CLK) disable iff (SRST)
		TOTAL_FAIL |-> !RND_VALID ##1 (TOTAL_FAIL && !RND_VALID);
	endproperty
	a_total_silent: assert property (p_total_silent) // RULE2
		else $error("word delivered after total failure");

	property p_fail_flush;
		@(posedge CLK) disable iff (SRST)
		$rose(HEALTH_FAIL) |=> !fifo_out_valid && !st_q.wfull
			&& (st_q.wcnt == WCNT_ZERO);
	endproperty
	a_fail_flush: assert property (p_fail_flush) // RULE3
		else $error("words kept after failure");

	// Window closing with a ones count out of bounds
	sequence s_win_bad;
		win_end && win_bad;
	endsequence

	property p_online_detect;
		@(posedge CLK) disable iff (SRST)
		s_win_bad |=> ONLINE_FAIL && !STARTUP_OK;
	endproperty
	a_online_detect: assert property (p_online_detect) // RULE4
		else $error("online defect not flagged");

	property p_startup_gate;
		@(posedge CLK) disable iff (SRST)
		$rose(STARTUP_OK) |-> $past(win_end) && !$past(win_bad) && !HEALTH_FAIL;
	endproperty
	a_startup_gate: assert property (p_startup_gate) // RULE5
		else $error("output opened without passing window");

	property p_no_early_out;
		@(posedge CLK) disable iff (SRST)
		(!STARTUP_OK || ONLINE_FAIL) |-> !RND_VALID;
	endproperty
	a_no_early_out: assert property (p_no_early_out) // RULE5
		else $error("word out before start-up or after defect");

	property p_continuous;
		@(posedge CLK) disable iff (SRST)
		gap_q < GAP_MAX;
	endproperty
	a_continuous: assert property (p_continuous) // RULE6
		else $error("online test verdict overdue");

	property p_word_full;
		@(posedge CLK) disable iff (SRST)
		$rose(st_q.wfull) |-> $past(samp) && ($past(st_q.wcnt) == WCNT_LAST);
	endproperty
	a_word_full: assert property (p_word_full) // RULE7
		else $error("word released before all bits shifted");

	property p_hold_word;
		@(posedge CLK) disable iff (SRST)
		(RND_VALID && !RND_READY) |=> (RND_VALID && $stable(RND_DATA)) || HEALTH_FAIL;
	endproperty
	a_hold_word: assert property (p_hold_word) // RULE9
		else $error("offered word dropped or changed");

	property p_sticky;
		@(posedge CLK) disable iff (SRST)
		HEALTH_FAIL |=> HEALTH_FAIL [*2];
	endproperty
	a_sticky: assert property (p_sticky) // RULE9
		else $error("failure status not sticky");

	// Sample that breaks a run of identical bits
	sequence s_run_break;
		samp && (rbit != st_q.run_bit);
	endsequence

	property p_run_restart;
		@(posedge CLK) disable iff (SRST)
		s_run_break |=> (st_q.run_len == RUN_ONE);
	endproperty
	a_run_restart: assert property (p_run_restart) // RULE1
		else $error("run counter not restarted on a changed bit");

	property p_word_entry;
		@(posedge CLK) disable iff (SRST)
		fifo_in_valid |-> STARTUP_OK && !HEALTH_FAIL;
	endproperty
	a_word_entry: assert property (p_word_entry) // RULE5
		else $error("word buffered while source untrusted");

	property p_window_restart;
		@(posedge CLK) disable iff (SRST)
		win_end |=> (st_q.win == WIN_ZERO) && (st_q.ones == ONES_ZERO);
	endproperty
	a_window_restart: assert property (p_window_restart) // RULE6
		else $error("online test window not restarted");

	// Window closing with a balanced ones count on a healthy source
	sequence s_win_good;
		win_end && !win_bad && !HEALTH_FAIL;
	endsequence

	property p_balance_pass;
		@(posedge CLK) disable iff (SRST)
		s_win_good |=> !ONLINE_FAIL;
	endproperty
	a_balance_pass: assert property (p_balance_pass) // RULE8
		else $error("balanced window flagged as defect");

endmodule : thg_gate

`default_nettype wire

// *** common/thg_pkg.sv ***
// Constants and types shared by the random word gate and its test bench
package thg_pkg;

	// Sampling rate of the raw entropy bit, derived from the system clock
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned SAMPLE_PERIOD_NS = 40;
	localparam int unsigned SAMPLE_CYC       = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int unsigned DIV_W            = 3;
	localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(SAMPLE_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO    = 3'h0;

	// Output word assembly
	localparam int unsigned WORD_W           = 32;
	localparam int unsigned WCNT_W           = 6;
	localparam logic [WCNT_W-1:0] WCNT_LAST  = WCNT_W'(WORD_W - 1);
	localparam logic [WCNT_W-1:0] WCNT_ZERO  = 6'h00;

	// Total failure test: a run of identical samples this long is a dead source
	localparam int unsigned RUN_W            = 6;
	localparam logic [RUN_W-1:0] RUN_LIMIT   = 6'h20;
	localparam logic [RUN_W-1:0] RUN_ONE     = 6'h01;

	// Online test: count of ones over a fixed window must stay within bounds
	localparam int unsigned WIN_W            = 10;
	localparam logic [WIN_W-1:0] WIN_LAST    = 10'h3FF;
	localparam logic [WIN_W-1:0] WIN_ZERO    = 10'h000;
	localparam int unsigned ONES_W           = 11;
	localparam logic [ONES_W-1:0] ONES_LO    = 11'h1C0;
	localparam logic [ONES_W-1:0] ONES_HI    = 11'h240;
	localparam logic [ONES_W-1:0] ONES_ZERO  = 11'h000;

	// Longest gap between two online test verdicts, in clock cycles
	localparam int unsigned GAP_W            = 13;
	localparam logic [GAP_W-1:0] GAP_MAX     = GAP_W'(SAMPLE_CYC * (int'(WIN_LAST) + 1));

	// Output buffer
	localparam int unsigned FIFO_DEPTH       = 4;

	// Health mode of the generator
	typedef enum logic [1:0] {
		THG_STARTUP,
		THG_RUN,
		THG_FAIL
	} thg_mode_t;

endpackage : thg_pkg

// *** verilog/thg_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
`default_nettype none

module thg_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	// DEPTH must be a power of two so the pointers wrap by themselves
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);
	localparam logic [PW-1:0] PTR_ONE  = PW'(1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rd;
		logic [PW-1:0]               wr;
		logic [CW-1:0]               cnt;
	} thg_fifo_st_t;

	thg_fifo_st_t st_q;
	thg_fifo_st_t st_d;
	logic         push;
	logic         pop;

	// Honest flags straight from the fill count
	assign in_ready  = (st_q.cnt != CNT_FULL);
	assign out_valid = (st_q.cnt != '0);
	assign out_data  = st_q.mem[st_q.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state; a flush drops every stored word at once
	always_comb
	begin
		st_d = st_q;
		if (flush)
		begin
			st_d.rd  = '0;
			st_d.wr  = '0;
			st_d.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				st_d.mem[st_q.wr] = in_data;
				st_d.wr = st_q.wr + PTR_ONE;
			end
			if (pop)
				st_d.rd = st_q.rd + PTR_ONE;
			if (push && !pop)
				st_d.cnt = st_q.cnt + CNT_ONE;
			else if (pop && !push)
				st_d.cnt = st_q.cnt - CNT_ONE;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (srst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

endmodule : thg_fifo

`default_nettype wire

// *** tb/thg_consumer.sv ***
// Consumer model that takes random words from the gate
`timescale 1ns/1ps
`default_nettype none

module thg_consumer (
	input  wire logic                       clk,
	input  wire logic                       stall,
	input  wire logic                       valid,
	input  wire logic [thg_pkg::WORD_W-1:0] data,
	output logic                            ready,
	output int                              n_words,
	output int                              n_ones
);
	import thg_pkg::*;

	int words_q = 0;
	int ones_q  = 0;

	// Ready follows the bench's stall, which moves only at falling edges
	assign ready   = !stall;
	assign n_words = words_q;
	assign n_ones  = ones_q;

	// A word counts only when offered and accepted at the same edge;
	// its ones are tallied so the bench can judge the bit balance
	always @(posedge clk)
		if (valid && ready)
		begin
			words_q <= words_q + 1;
			ones_q  <= ones_q + $countones(data);
		end
endmodule : thg_consumer

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the random word gate
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import thg_pkg::*;

	typedef struct {logic [3:0] pat; logic tf; logic of; logic ok;} thg_row_t;

	logic              clk, srst, stall, rnd_valid, rnd_ready;
	logic              raw_bit = 1'b0;
	logic              startup_ok, total_fail, online_fail, health_fail, data_chk;
	logic [WORD_W-1:0] rnd_data;
	logic [3:0]        pat;
	int                errors, n_compared, n_words, n0, n_ones, n1;
	int                tick = 0;
	thg_row_t          rows[5];

	thg_gate u_dut (.CLK(clk), .SRST(srst), .RAW_BIT(raw_bit), .RND_DATA(rnd_data),
		.RND_VALID(rnd_valid), .RND_READY(rnd_ready), .STARTUP_OK(startup_ok),
		.TOTAL_FAIL(total_fail), .ONLINE_FAIL(online_fail), .HEALTH_FAIL(health_fail));

	thg_consumer u_cons (.clk(clk), .stall(stall), .valid(rnd_valid), .data(rnd_data),
		.ready(rnd_ready), .n_words(n_words), .n_ones(n_ones));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Raw bit walks a 4-sample pattern, one step per sample period of 4 clocks
	always @(negedge clk)
		raw_bit <= pat[tick[3:2]];

	// Gating watch every cycle, word shape check, and a hang limit
	always @(posedge clk)
	begin
		tick <= tick + 1;
		if (!srst)
			check("gating", 32'(rnd_valid && (!startup_ok || health_fail)), 32'h0);
		if (data_chk && rnd_valid && rnd_ready)
			check("word", rnd_data ^ {rnd_data[30:0], rnd_data[31]}, 32'hFFFFFFFF);
		if (tick == 60000)
		begin
			errors++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("Counts: %0d compared, %0d errors", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	// Reset for 5 cycles; all outputs must be zero at its end, while reset is still held
	task automatic do_reset(input logic [3:0] p);
		srst = 1'b1;
		pat = p;
		repeat (5) @(negedge clk);
		check("reset", 32'({rnd_valid, startup_ok, health_fail, total_fail, online_fail}), 32'h0);
		check("reset data", rnd_data, 32'h0);
		srst = 1'b0;
	endtask : do_reset

	// Bounded wait for a status flag: 0 start-up, 1 dead source, 2 online defect
	task automatic wait_flag(input int which, input int lim);
		for (int i = 0; i < lim; i++)
		begin
			@(negedge clk);
			if ((which == 0 && startup_ok) || (which == 1 && total_fail) ||
				(which == 2 && online_fail))
				break;
		end
	endtask : wait_flag

	initial
	begin
		srst = 1'b1;
		pat = 4'hA;
		stall = 1'b0;
		data_chk = 1'b0;
		errors = 0;
		n_compared = 0;
		// A stuck source also fails the running window, so both flags rise
		rows = '{'{4'hA, 0, 0, 1}, '{4'h0, 1, 1, 0}, '{4'hF, 1, 1, 0},
			'{4'hE, 0, 1, 0}, '{4'h1, 0, 1, 0}};
		// Each pattern from reset; flags judged after the first full window
		foreach (rows[i])
		begin
			do_reset(rows[i].pat);
			repeat (4400) @(negedge clk);
			check("total", 32'(total_fail), 32'(rows[i].tf));
			check("online", 32'(online_fail), 32'(rows[i].of));
			check("startup", 32'(startup_ok), 32'(rows[i].ok));
			check("health", 32'(health_fail), 32'(rows[i].tf | rows[i].of));
			$display("Row %0d done", i);
		end
		// Consumer stalls until the buffer fills, then drains it back to back
		do_reset(4'hA);
		stall = 1'b1;
		data_chk = 1'b1;
		wait_flag(0, 5000);
		repeat (1000) @(negedge clk);
		check("full valid", 32'(rnd_valid), 32'h1);
		n0 = n_words;
		n1 = n_ones;
		stall = 1'b0;
		repeat (FIFO_DEPTH) @(negedge clk);
		check("drain", 32'(n_words - n0), 32'(FIFO_DEPTH));
		check("balance", 32'(n_ones - n1), 32'(FIFO_DEPTH * WORD_W / 2));
		repeat (300) @(negedge clk);
		data_chk = 1'b0;
		$display("Buffer test done");
		// Source dies in operation; output stops and the flag stays set
		pat = 4'h0;
		wait_flag(1, 200);
		check("dead", 32'(total_fail), 32'h1);
		pat = 4'hA;
		repeat (500) @(negedge clk);
		check("sticky", 32'({total_fail, startup_ok, rnd_valid}), 32'h4);
		$display("Dead source test done");
		// Source turns biased after start-up; the running test must catch it
		do_reset(4'hA);
		wait_flag(0, 5000);
		check("up", 32'(startup_ok), 32'h1);
		pat = 4'hE;
		wait_flag(2, 9000);
		check("biased", 32'({online_fail, total_fail, rnd_valid}), 32'h4);
		$display("Biased source test done");
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
